// file: hw/jbs_top.sv
/*
  Debug and test port: selects, once per chip reset, between routing the
  test access port to the emulation debug logic or to boundary scan, and
  implements the boundary scan instructions, boundary register and
  identification code. Assumes ref_clk runs freely, TCK comes from the
  tester and may stop, and pads are muxed through pad_out/pad_oe.

  // Behaviour
  // RQ1 - Board holds factory test pin low
  // RQ2 - Select low routes port to emulation logic
  // RQ3 - Select high connects port to boundary scan
  // RQ4 - Select level takes effect only at reset
  // RQ5 - Tester resets chip after changing select
  // RQ6 - SAMPLE, EXTEST and BYPASS behave as standard
  // RQ7 - Emulation mode answers with processor identifier
  // RQ8 - Boundary register holds 96 pad cells
  // RQ9 - Each pad has input, output, control cells
  // RQ10 - Output cell drives pad, input cell captures
  // RQ11 - Control cell sets pad direction
  // RQ12 - Input, output, control order; bit 0 erase
  // RQ13 - Reduced variant omits footnoted pad groups
  // RQ14 - Identification: version, part, maker fields
  // RQ15 - Identification bit 0 always one
  // RQ16 - Debug channel flags raise debug interrupt
  // RQ17 - Emulation access can be blocked
  // RQ18 - Three processor scan chains reached via port
  // RQ19 - Halt mode register dump through emulation
  // RQ20 - Standard sixteen-state TAP, TDO on falling
*/
`timescale 1ns/1ns
`default_nettype none

module jbs_top #(
  parameter logic [3:0] ID_VERSION = 4'h1, // Arbitrary value
  parameter logic [15:0] ID_PART = 16'h1234, // Arbitrary value
  parameter logic [10:0] ID_MAKER = 11'h2A5, // Arbitrary value
  parameter bit REDUCED = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic port_function_select,
  input wire logic factory_test_pin,
  output logic factory_test_fault,
  output logic ice_selected,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  output logic ice_tms,
  output logic ice_tdi,
  input wire logic ice_tdo,
  input wire logic ice_tdo_oe,
  input wire logic ice_block,
  input wire logic debug_channel_tx_flag,
  input wire logic debug_channel_rx_flag,
  output logic debug_channel_irq,
  input wire logic erase_pin,
  input wire logic [jbs_pkg::NUM_PADS-1:0] pad_in,
  input wire logic [jbs_pkg::NUM_PADS-1:0] core_out,
  input wire logic [jbs_pkg::NUM_PADS-1:0] core_oe,
  output logic [jbs_pkg::NUM_PADS-1:0] pad_out,
  output logic [jbs_pkg::NUM_PADS-1:0] pad_oe
);
  import jbs_pkg::*;

  localparam logic [ID_W-1:0] ID_VALUE =
    {ID_VERSION, ID_PART, ID_MAKER, ID_FIXED_VAL};

  // ref_clk domain state
  logic sel_s1_reg;
  logic sel_s2_reg;
  logic mode_reg;
  logic mode_done_reg;
  logic tst_s1_reg;
  logic tst_s2_reg;
  logic fault_reg;
  logic irq_reg;

  // TCK domain state
  logic rst_s1_reg;
  logic rst_tck;
  logic mode_t1_reg;
  logic bscan_tck;
  logic blk_t1_reg;
  logic block_tck;
  logic [IR_W-1:0] ir_sr_reg;
  logic [IR_W-1:0] ir_reg;
  logic [ID_W-1:0] id_sr_reg;
  logic bypass_reg;
  logic tdo_reg;
  logic tdo_oe_reg;

  jbs_tap_state_t tap_state;
  jbs_tap_if tap ();

  // Mode pin comes from outside: two flops before use. This pair runs
  // through reset, so the latch sees the pin and not a reset value
  always_ff @(posedge ref_clk) begin
    sel_s1_reg <= port_function_select;
    sel_s2_reg <= sel_s1_reg;
  end

  // Test pin comes from outside as well: two flops before use
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tst_s1_reg <= 1'b0;
      tst_s2_reg <= 1'b0;
    end else begin
      tst_s1_reg <= factory_test_pin;
      tst_s2_reg <= tst_s1_reg;
    end
  end

  // Select is latched once after reset release; later changes are ignored
  // until the next chip reset, so a live switch cannot corrupt a session
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= MODE_ICE;
      mode_done_reg <= 1'b0;
    end else if (!mode_done_reg) begin
      mode_reg <= sel_s2_reg; // RQ4
      mode_done_reg <= 1'b1;
    end
  end

  // Any high level on the factory test pin is flagged for the system
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fault_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      fault_reg <= tst_s2_reg; // RQ1
      irq_reg <= debug_channel_tx_flag | debug_channel_rx_flag; // RQ16
    end
  end

  assign factory_test_fault = fault_reg;
  assign debug_channel_irq = irq_reg;
  assign ice_selected = mode_done_reg && (mode_reg == MODE_ICE); // RQ2

  // TCK domain reset: asserted at once, released after two TCK edges
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      rst_s1_reg <= 1'b1;
      rst_tck <= 1'b1;
    end else begin
      rst_s1_reg <= 1'b0;
      rst_tck <= rst_s1_reg;
    end
  end

  // Mode and block levels cross into the TCK domain through two flops
  always_ff @(posedge tck or posedge rst_tck) begin
    if (rst_tck) begin
      mode_t1_reg <= 1'b0;
      bscan_tck <= 1'b0;
      blk_t1_reg <= 1'b0;
      block_tck <= 1'b0;
    end else begin
      mode_t1_reg <= mode_done_reg && (mode_reg == MODE_BSCAN);
      bscan_tck <= mode_t1_reg; // RQ3
      blk_t1_reg <= ice_block;
      block_tck <= blk_t1_reg;
    end
  end

  // Emulation logic sees TMS only in its mode and when not blocked, TDI always;
  // holding its TMS high parks its own TAP (and its three scan chains) in
  // reset, which is how access is denied without glitching TCK
  assign ice_tms = (bscan_tck || block_tck) ? 1'b1 : tms; // RQ2 RQ17 RQ18
  assign ice_tdi = tdi; // RQ19

  jbs_tap_fsm u_fsm (
    .tck(tck),
    .rst_tck(rst_tck),
    .enable(bscan_tck),
    .tms(tms),
    .state(tap_state),
    .tap(tap.fsm)
  );

  // Instruction decode
  wire is_extest = (ir_reg == IR_EXTEST);
  wire is_sample = (ir_reg == IR_SAMPLE);
  wire is_idcode = (ir_reg == IR_IDCODE);
  wire bsr_sel = is_extest || is_sample; // RQ6
  wire byp_sel = !bsr_sel && !is_idcode; // RQ6
  wire bsr_tdo;

  jbs_boundary #(
    .PADS(NUM_PADS),
    .REDUCED(REDUCED)
  ) u_bsr (
    .tck(tck),
    .rst_tck(rst_tck),
    .tap(tap.user),
    .selected(bsr_sel),
    .extest(bscan_tck && is_extest),
    .tdi(tdi),
    .chain_tdo(bsr_tdo),
    .erase_pin(erase_pin),
    .pad_in(pad_in),
    .core_out(core_out),
    .core_oe(core_oe),
    .pad_out(pad_out),
    .pad_oe(pad_oe)
  ); // RQ8 RQ9 RQ12

  // Instruction shift register captures the fixed 01 pattern
  always_ff @(posedge tck or posedge rst_tck) begin
    if (rst_tck) begin
      ir_sr_reg <= IR_CAPT;
    end else if (tap.cap_ir) begin
      ir_sr_reg <= IR_CAPT;
    end else if (tap.shf_ir) begin
      ir_sr_reg <= {tdi, ir_sr_reg[IR_W-1:1]};
    end
  end

  // Active instruction changes on the falling edge in Update-IR
  always_ff @(negedge tck or posedge rst_tck) begin
    if (rst_tck) begin
      ir_reg <= IR_IDCODE;
    end else if (tap.tlr) begin
      ir_reg <= IR_IDCODE;
    end else if (tap.upd_ir) begin
      ir_reg <= ir_sr_reg; // RQ6
    end
  end

  // Identification and bypass data registers
  always_ff @(posedge tck or posedge rst_tck) begin
    if (rst_tck) begin
      id_sr_reg <= ID_VALUE;
      bypass_reg <= 1'b0;
    end else begin
      if (is_idcode && tap.cap_dr) begin
        id_sr_reg <= ID_VALUE; // RQ14 RQ15
      end else if (is_idcode && tap.shf_dr) begin
        id_sr_reg <= {tdi, id_sr_reg[ID_W-1:1]};
      end
      if (byp_sel && tap.cap_dr) begin
        bypass_reg <= 1'b0; // RQ6
      end else if (byp_sel && tap.shf_dr) begin
        bypass_reg <= tdi;
      end
    end
  end

  // Serial output source for the current shift state
  wire dr_bit = bsr_sel ? bsr_tdo : (is_idcode ? id_sr_reg[0] : bypass_reg);
  wire tdo_next = tap.shf_ir ? ir_sr_reg[0] : dr_bit;
  wire tdo_en_next = tap.shf_ir || tap.shf_dr;

  // TDO changes on falling TCK so the tester samples a settled bit
  always_ff @(negedge tck or posedge rst_tck) begin
    if (rst_tck) begin
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else begin
      tdo_reg <= tdo_next; // RQ20
      tdo_oe_reg <= tdo_en_next;
    end
  end

  // In emulation mode the processor's own TAP answers, identifier included
  assign tdo = bscan_tck ? tdo_reg : ice_tdo; // RQ7
  assign tdo_oe = bscan_tck ? tdo_oe_reg : (ice_tdo_oe && !block_tck);

  mode_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ4
    mode_done_reg |=> $stable(mode_reg) && mode_done_reg)
    else $error("Port function changed without a chip reset");
  mode_take_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ3
    $rose(mode_done_reg) |-> mode_reg == $past(sel_s2_reg))
    else $error("Port function not taken from the synchronised select");
  ice_park_a: assert property (@(posedge tck) disable iff (rst_tck) // RQ2
    bscan_tck || block_tck |-> ice_tms)
    else $error("Emulation TAP not parked while not routed");
  ice_pass_a: assert property (@(posedge tck) disable iff (rst_tck) // RQ17
    !bscan_tck && !block_tck |-> ice_tms == tms && tdo == ice_tdo)
    else $error("Emulation path not passed through");
  id_fields_a: assert property (@(posedge tck) disable iff (rst_tck) // RQ14
    is_idcode && tap.cap_dr |=> id_sr_reg[ID_W-1:ID_MAKER_LSB] == ID_VALUE[ID_W-1:1])
    else $error("Identification fields wrong after capture");
  id_bit0_a: assert property (@(posedge tck) disable iff (rst_tck) // RQ15
    is_idcode && tap.cap_dr |=> id_sr_reg[ID_FIXED_BIT] == 1'b1)
    else $error("Identification bit 0 not one");
  bypass_cap_a: assert property (@(posedge tck) disable iff (rst_tck) // RQ6
    byp_sel && tap.cap_dr ##1 tap.shf_dr |=> bypass_reg == $past(tdi))
    else $error("Bypass register not one-bit delay");
  ir_update_a: assert property (@(negedge tck) disable iff (rst_tck) // RQ6
    tap.upd_ir |=> ir_reg == $past(ir_sr_reg, 1))
    else $error("Instruction not taken at Update-IR");
  tdo_oe_shift_a: assert property (@(negedge tck) disable iff (rst_tck) // RQ20
    bscan_tck && (tap_state == ST_SHF_DR || tap_state == ST_SHF_IR) |=> tdo_oe)
    else $error("TDO not enabled in a shift state");

  ice_mode_c: cover property (@(posedge ref_clk) disable iff (rst)
    !mode_done_reg ##1 ice_selected);
  idcode_c: cover property (@(posedge tck) disable iff (rst_tck)
    is_idcode && tap.cap_dr ##1 tap.shf_dr [*8]);
  extest_c: cover property (@(posedge tck) disable iff (rst_tck)
    is_extest && tap.upd_dr);
  bypass_c: cover property (@(posedge tck) disable iff (rst_tck)
    byp_sel && tap.shf_dr ##1 tap.shf_dr);

endmodule

`default_nettype wire

// file: hw/jbs_pkg.sv
/*
  Package for the debug and test port: instruction codes, identification
  field positions, boundary register layout and the TAP state encoding.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package jbs_pkg;

  // Instruction register
  localparam int IR_W = 4;
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_SAMPLE = 4'h1;
  localparam logic [3:0] IR_IDCODE = 4'h2;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [3:0] IR_CAPT = 4'h5; // Low two bits 01 as the standard wants

  // Identification code layout
  localparam int ID_W = 32;
  localparam int ID_VER_LSB = 28;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MAKER_LSB = 1;
  localparam int ID_FIXED_BIT = 0;
  localparam logic ID_FIXED_VAL = 1'b1;

  // Boundary register layout: one erase input cell plus three cells per pad
  localparam int NUM_PADS = 32;
  localparam int CELLS_PER_PAD = 3;
  localparam int CELL_CTRL = 0;
  localparam int CELL_OUT = 1;
  localparam int CELL_IN = 2;
  localparam int BSR_LEN = NUM_PADS * CELLS_PER_PAD + 1;
  // Pad groups absent on the reduced-pin variant
  localparam logic [31:0] PAD_ABSENT_MASK = 32'h2070_0787;

  // Port function chosen at reset
  localparam logic MODE_ICE = 1'b0;
  localparam logic MODE_BSCAN = 1'b1;

  // TAP controller states, one-hot
  typedef enum logic [15:0] {
    ST_TLR = 16'h0001,
    ST_RTI = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SHF_DR = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PAU_DR = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SHF_IR = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PAU_IR = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } jbs_tap_state_t;

endpackage

`default_nettype wire

// file: hw/jbs_tap_if.sv
/*
  Decoded TAP controller phases, passed from the state machine to the
  instruction and data registers. All signals live in the TCK domain.
*/
`timescale 1ns/1ns
`default_nettype none

interface jbs_tap_if;
  logic tlr;
  logic cap_dr;
  logic shf_dr;
  logic upd_dr;
  logic cap_ir;
  logic shf_ir;
  logic upd_ir;

  modport fsm (output tlr, cap_dr, shf_dr, upd_dr, cap_ir, shf_ir, upd_ir);
  modport user (input tlr, cap_dr, shf_dr, upd_dr, cap_ir, shf_ir, upd_ir);
endinterface

`default_nettype wire

// file: hw/jbs_tap_fsm.sv
/*
  Sixteen-state TAP controller, advanced on rising TCK under TMS.
  Assumes TMS is launched by the tester relative to TCK; enable low holds
  the controller in Test-Logic-Reset.
*/
`timescale 1ns/1ns
`default_nettype none

module jbs_tap_fsm (
  input wire logic tck,
  input wire logic rst_tck,
  input wire logic enable,
  input wire logic tms,
  output jbs_pkg::jbs_tap_state_t state,
  jbs_tap_if.fsm tap
);
  import jbs_pkg::*;

  jbs_tap_state_t state_reg;
  jbs_tap_state_t state_next;

  // Next state per the standard diagram
  always_comb begin
    case (state_reg)
      ST_TLR: state_next = tms ? ST_TLR : ST_RTI;
      ST_RTI: state_next = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: state_next = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_next = tms ? ST_EX1_DR : ST_SHF_DR;
      ST_SHF_DR: state_next = tms ? ST_EX1_DR : ST_SHF_DR;
      ST_EX1_DR: state_next = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: state_next = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: state_next = tms ? ST_UPD_DR : ST_SHF_DR;
      ST_UPD_DR: state_next = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: state_next = tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: state_next = tms ? ST_EX1_IR : ST_SHF_IR;
      ST_SHF_IR: state_next = tms ? ST_EX1_IR : ST_SHF_IR;
      ST_EX1_IR: state_next = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: state_next = tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: state_next = tms ? ST_UPD_IR : ST_SHF_IR;
      ST_UPD_IR: state_next = tms ? ST_SEL_DR : ST_RTI;
      default: state_next = ST_TLR;
    endcase
  end

  // State register; disabled port sits in reset so it ignores TMS
  always_ff @(posedge tck or posedge rst_tck) begin
    if (rst_tck) begin
      state_reg <= ST_TLR;
    end else begin
      state_reg <= enable ? state_next : ST_TLR; // RQ20
    end
  end

  assign state = state_reg;
  assign tap.tlr = (state_reg == ST_TLR);
  assign tap.cap_dr = (state_reg == ST_CAP_DR);
  assign tap.shf_dr = (state_reg == ST_SHF_DR);
  assign tap.upd_dr = (state_reg == ST_UPD_DR);
  assign tap.cap_ir = (state_reg == ST_CAP_IR);
  assign tap.shf_ir = (state_reg == ST_SHF_IR);
  assign tap.upd_ir = (state_reg == ST_UPD_IR);

  tms_reset_a: assert property (@(posedge tck) disable iff (rst_tck) // RQ20
    tms [*5] |=> state_reg == ST_TLR)
    else $error("Five TMS highs did not reach reset state");
  dr_path_a: assert property (@(posedge tck) disable iff (rst_tck) // RQ20
    enable && state_reg == ST_RTI && tms ##1 !tms ##1 !tms |=> state_reg == ST_SHF_DR)
    else $error("TMS 1,0,0 from idle did not reach shift-DR");

endmodule

`default_nettype wire

// file: hw/jbs_boundary.sv
/*
  Boundary register: an erase input cell at bit 0 and a control, output
  and input cell per pad above it. Capture and shift on rising TCK, update
  on falling TCK. Assumes pad levels are stable across a capture edge.
*/
`timescale 1ns/1ns
`default_nettype none

module jbs_boundary #(
  parameter int PADS = jbs_pkg::NUM_PADS,
  parameter bit REDUCED = 1'b0
) (
  input wire logic tck,
  input wire logic rst_tck,
  jbs_tap_if.user tap,
  input wire logic selected,
  input wire logic extest,
  input wire logic tdi,
  output logic chain_tdo,
  input wire logic erase_pin,
  input wire logic [PADS-1:0] pad_in,
  input wire logic [PADS-1:0] core_out,
  input wire logic [PADS-1:0] core_oe,
  output logic [PADS-1:0] pad_out,
  output logic [PADS-1:0] pad_oe
);
  import jbs_pkg::*;

  localparam int LEN = PADS * CELLS_PER_PAD + 1;

  logic [LEN-1:0] shift_reg;
  logic [LEN-1:0] upd_reg;
  logic [LEN:0] link; // Serial path, absent cells bypassed
  logic [LEN-1:0] capt;

  assign link[LEN] = tdi;
  assign chain_tdo = link[0];

  // One cell per bit; cell kind follows its position inside the pad group
  for (genvar i = 0; i < LEN; i++) begin : g_cell
    localparam int GRP = (i == 0) ? 0 : (i - 1) / CELLS_PER_PAD;
    localparam int KIND = (i == 0) ? CELL_IN : (i - 1) % CELLS_PER_PAD;
    localparam bit HAS = (i == 0) || !(REDUCED && PAD_ABSENT_MASK[GRP]); // RQ13
    if (!HAS) begin : g_absent
      assign link[i] = link[i + 1];
      assign capt[i] = 1'b0;
      assign shift_reg[i] = 1'b0;
      assign upd_reg[i] = 1'b0;
    end else begin : g_present
      if (i == 0) begin : g_erase
        assign capt[i] = erase_pin; // RQ12
      end else if (KIND == CELL_IN) begin : g_in
        assign capt[i] = pad_in[GRP]; // RQ10
      end else if (KIND == CELL_OUT) begin : g_out
        assign capt[i] = core_out[GRP];
      end else begin : g_ctl
        assign capt[i] = core_oe[GRP];
      end
      assign link[i] = shift_reg[i];
      // Capture or shift when this register is the selected data path
      always_ff @(posedge tck or posedge rst_tck) begin
        if (rst_tck) begin
          shift_reg[i] <= 1'b0;
        end else if (selected && tap.cap_dr) begin
          shift_reg[i] <= capt[i];
        end else if (selected && tap.shf_dr) begin
          shift_reg[i] <= link[i + 1];
        end
      end
      // Update stage holds pad drive steady while shifting continues
      always_ff @(negedge tck or posedge rst_tck) begin
        if (rst_tck) begin
          upd_reg[i] <= 1'b0;
        end else if (tap.tlr) begin
          upd_reg[i] <= 1'b0;
        end else if (selected && tap.upd_dr) begin
          upd_reg[i] <= shift_reg[i];
        end
      end
    end
  end

  // Pad drive: update cells during external test, core otherwise
  for (genvar p = 0; p < PADS; p++) begin : g_pad
    localparam int BASE = p * CELLS_PER_PAD + 1;
    assign pad_out[p] = extest ? upd_reg[BASE + CELL_OUT] : core_out[p]; // RQ10
    assign pad_oe[p] = extest ? upd_reg[BASE + CELL_CTRL] : core_oe[p]; // RQ11
  end

  extest_drive_a: assert property (@(posedge tck) disable iff (rst_tck) // RQ10
    extest && tap.shf_dr |-> $stable(pad_out[PADS-1]) && pad_out[PADS-1] == upd_reg[LEN-2])
    else $error("Top pad not held from its output cell while shifting");

endmodule

`default_nettype wire

// file: verif/jbs_tester.sv
/*
  Model of the external tester on the test access port. TCK runs only
  inside frames and stands low between them. TMS and TDI are driven, and
  TDO is taken just before each rising edge.
  Assumes the port keeps the standard sixteen-state controller.
*/
`timescale 1ns/1ns
`default_nettype none

module jbs_tester (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  localparam int HALF = 62;

  // Idle levels at time zero
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One TCK period; TDO was updated on the previous falling edge
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #HALF;
    o = tdo;
    tck = 1'b1;
    #(HALF + 1);
    tck = 1'b0;
  endtask

  // TMS high keeps or returns the controller to reset; TDI toggles as no data
  task automatic idle(input int n);
    logic o;
    for (int i = 0; i < n; i++) begin
      step(1'b1, ~tdi, o);
    end
  endtask

  // From reset or idle through an instruction scan back to idle
  task automatic ir_scan(input logic [3:0] code, output logic [3:0] got);
    logic o;
    step(1'b0, ~tdi, o);
    step(1'b1, ~tdi, o);
    step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
    step(1'b0, ~tdi, o);
    for (int k = 0; k < 4; k++) begin
      step(k == 3, code[k], got[k]);
    end
    step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
  endtask

  // Data scan of n bits, first bit out is bit 0
  task automatic dr_scan(input int n, input logic [127:0] din, output logic [127:0] dout);
    logic o;
    dout = '0;
    step(1'b0, ~tdi, o);
    step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
    step(1'b0, ~tdi, o);
    for (int k = 0; k < n; k++) begin
      step(k == n - 1, din[k], dout[k]);
    end
    step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
  endtask
endmodule

`default_nettype wire

// file: verif/jtag_boundary_scan_mode_select_tb.sv
/*
  Self-checking bench for the debug and test port: a table of system-side
  cases, then boundary scan and emulation scenarios through the tester.
  Assumes the package, the interface and all design modules compile first.
*/
`timescale 1ns/1ns
`default_nettype none

module jtag_boundary_scan_mode_select_tb;
  import jbs_pkg::*;
  localparam int LIMIT = 20000;
  localparam logic [3:0] ID_V = 4'h3; // Arbitrary value
  localparam logic [15:0] ID_P = 16'hA5C1; // Arbitrary value
  localparam logic [10:0] ID_M = 11'h155; // Arbitrary value
  // Row: tx flag, rx flag, test pin, expected irq, expected fault
  // Last row returns the test pin low for the rest of the run
  localparam logic [4:0] ROWS [5] = '{5'h12, 5'h0A, 5'h1F, 5'h05, 5'h00};
  localparam logic [3:0] BYP [2] = '{IR_BYPASS, 4'h7};

  logic ref_clk, rst, sel, ftp, ftf, ice_sel, tck, tms, tdi, tdo, tdo_oe;
  logic ice_tms, ice_tdi, ice_tdo, ice_tdo_oe, ice_block, tx_flag, rx_flag, irq, erase;
  logic [NUM_PADS-1:0] pad_in, core_out, core_oe, pad_out, pad_oe;
  logic [127:0] v, e, pat;
  logic [3:0] c;
  logic o;
  int errors, check_count, cycles;

  jbs_top #(.ID_VERSION(ID_V), .ID_PART(ID_P), .ID_MAKER(ID_M), .REDUCED(1'b0)) DUT (
    .ref_clk(ref_clk), .rst(rst), .port_function_select(sel), .factory_test_pin(ftp),
    .factory_test_fault(ftf), .ice_selected(ice_sel), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .ice_tms(ice_tms), .ice_tdi(ice_tdi), .ice_tdo(ice_tdo),
    .ice_tdo_oe(ice_tdo_oe), .ice_block(ice_block), .debug_channel_tx_flag(tx_flag),
    .debug_channel_rx_flag(rx_flag), .debug_channel_irq(irq), .erase_pin(erase),
    .pad_in(pad_in), .core_out(core_out), .core_oe(core_oe), .pad_out(pad_out),
    .pad_oe(pad_oe)
  );

  // Undriven TDO has no pull: the tester sees the inverse of the last bit
  jbs_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_oe ? tdo : !tdo));

  // System clock, 40 ns
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Mode pin is held through the whole reset so the latch sees a settled level
  task automatic do_reset(input logic s);
    @(posedge ref_clk);
    rst <= 1'b1;
    sel <= s;
    ftp <= 1'b0;
    repeat (12) @(posedge ref_clk);
    check("irq in reset", 0, irq);
    check("fault in reset", 0, ftf);
    check("tdo_oe in reset", 0, tdo_oe);
    rst <= 1'b0;
    @(posedge ref_clk);
    tester.idle(6);
    $display("done: reset");
  endtask

  // Hang guard on the system clock
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      $display("[ERR] run time expected below %0d seen %0d", LIMIT, cycles);
      finish_test();
    end
  end

  initial begin
    {rst, sel, ftp, ice_tdo, ice_tdo_oe, ice_block, tx_flag, rx_flag, erase} = '0;
    {pad_in, core_out, core_oe} = '0;
    do_reset(1'b1);
    // Table of system-side cases
    foreach (ROWS[i]) begin
      @(posedge ref_clk);
      {tx_flag, rx_flag, ftp} <= ROWS[i][4:2];
      repeat (4) @(posedge ref_clk);
      check("debug irq", ROWS[i][1], irq);
      check("test fault", ROWS[i][0], ftf);
    end
    $display("done: rows");
    // Identification read by default after reset, bit 0 first
    tester.dr_scan(32, '0, v);
    check("idcode", {ID_V, ID_P, ID_M, 1'b1}, v[31:0]);
    check("tdo_oe idle", 0, tdo_oe);
    // Bypass, including an unused code, adds one zero-captured stage
    foreach (BYP[i]) begin
      tester.ir_scan(BYP[i], c);
      check("ir capture", IR_CAPT, c);
      tester.dr_scan(8, 128'h00B5, v);
      check("bypass", 8'h6A, v[7:0]);
    end
    $display("done: id and bypass");
    // Sample: erase cell at bit 0, then control, output, input per pad
    @(posedge ref_clk);
    pad_in <= 32'hC3A5_0F96;
    core_out <= 32'h5A3C_E187;
    core_oe <= 32'h0FF0_33CC;
    erase <= 1'b1;
    tester.ir_scan(IR_SAMPLE, c);
    tester.dr_scan(BSR_LEN, '0, v);
    e = '0;
    e[0] = erase;
    for (int p = 0; p < NUM_PADS; p++) begin
      e[3*p+1] = core_oe[p];
      e[3*p+2] = core_out[p];
      e[3*p+3] = pad_in[p];
    end
    check("sample chain", e, v);
    check("sample pads", core_out, pad_out);
    // External test drives the pads from the update cells
    pat = {4{32'h9E37_79B9}};
    tester.ir_scan(IR_EXTEST, c);
    tester.dr_scan(BSR_LEN, pat, v);
    check("extest capture", e[3:3], v[3:3]);
    for (int p = 0; p < NUM_PADS; p++) begin
      e[p] = pat[3*p+2];
      e[p+32] = pat[3*p+1];
    end
    check("extest out", e[31:0], pad_out);
    check("extest oe", e[63:32], pad_oe);
    $display("done: sample and extest");
    // Emulation mode: port passes straight to the processor debug logic
    do_reset(1'b0);
    check("ice selected", 1, ice_sel);
    @(posedge ref_clk);
    ice_tdo <= 1'b1;
    ice_tdo_oe <= 1'b1;
    tester.step(1'b0, 1'b1, o);
    check("ice tms", 0, ice_tms);
    check("ice tdi", tdi, ice_tdi);
    check("ice tdo", 1, tdo);
    check("ice tdo_oe", 1, tdo_oe);
    @(posedge ref_clk);
    ice_block <= 1'b1;
    tester.idle(3);
    tester.step(1'b0, 1'b0, o);
    check("blocked tms", 1, ice_tms);
    check("blocked oe", 0, tdo_oe);
    // Mode pin change without reset must not switch the port
    @(posedge ref_clk);
    ice_block <= 1'b0;
    ice_tdo_oe <= 1'b0;
    sel <= 1'b1;
    repeat (8) @(posedge ref_clk);
    check("mode held", 1, ice_sel);
    do_reset(1'b1);
    check("bscan selected", 0, ice_sel);
    tester.dr_scan(32, '0, v);
    check("idcode again", {ID_V, ID_P, ID_M, 1'b1}, v[31:0]);
    $display("done: mode select");
    finish_test();
  end
endmodule

`default_nettype wire
